// ### hw/ulsuf_line_status.sv
// Module: upper five flags of the UART line status register
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Bit 7 is one while any character in the receive FIFO carries a parity, framing or break tag.
// - Bit 7 clears by itself once no remaining character in the receive FIFO carries a tag.
// - Outside FIFO mode bit 6 is one only while holding and shift registers are both empty.
// - In FIFO mode bit 6 is one when the transmit FIFO and the shift register are both empty.
// - Outside FIFO mode bit 5 sets on a move into the shift register and clears on a host write.
// - An interrupt request stands while bit 5 is one and its interrupt enable is set.
// - In FIFO mode bit 5 sets when the transmit FIFO is empty and clears once a byte is written.
// - Bit 4 sets when the receive line has been low for one whole character frame.
// - In FIFO mode each break condition loads one break character, however long it lasts; a full receive FIFO stores no tag but break_load still pulses.
// - Bit 3 sets when a received character lacks a valid stop bit.
// - In FIFO mode bit 3 reports the character at the head of the receive FIFO.
// - After reset bits 7, 4 and 3 read zero.

module ulsuf_line_status #(
  parameter int unsigned RX_DEPTH = ulsuf_pkg::RX_DEPTH_DEF
) (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    nrst,
  // Mode and enables
  input  wire logic                    fifo_mode,
  input  wire logic                    thr_int_en,
  // Transmit side
  input  wire logic                    tx_host_write,
  input  wire logic                    tx_load_shift,
  input  wire logic                    tx_fifo_empty,
  input  wire logic                    tx_shift_empty,
  // Receive side
  input  wire logic                    rx_line,
  input  wire logic                    rx_bit_tick,
  input  wire logic [ulsuf_pkg::FRAME_W-1:0] rx_frame_bits,
  input  wire logic                    rx_char_push,
  input  wire ulsuf_pkg::ulsuf_tag_t   rx_char_tag,
  input  wire logic                    rx_char_pop,
  // Status out
  output var  ulsuf_pkg::ulsuf_status_t line_status,
  output logic                         thr_irq,
  output logic                         break_load
);

  // ****************************************
  // Sizes and checks
  // ****************************************
  localparam int unsigned AW = $clog2(RX_DEPTH);
  localparam int unsigned CW = $clog2(RX_DEPTH + 1);

  // Pointer wrap relies on a power-of-two depth
  if (RX_DEPTH < 2 || (RX_DEPTH & (RX_DEPTH - 1)) != 0) begin : g_depth_chk
    $error("RX_DEPTH must be a power of two, at least 2");
  end

  function automatic logic tag_any(input ulsuf_pkg::ulsuf_tag_t t);
    tag_any = t.parity | t.framing | t.brk;
  endfunction

  // ****************************************
  // Break detector
  // ****************************************
  ulsuf_pkg::ulsuf_brk_state_t  brk_st_q, brk_st_d;
  logic [ulsuf_pkg::FRAME_W-1:0] low_cnt_q, low_cnt_d;
  logic                          brk_fire;

  always_comb begin
    brk_st_d  = brk_st_q;
    low_cnt_d = low_cnt_q;
    brk_fire  = 1'b0;
    case (brk_st_q)
      ulsuf_pkg::BRK_IDLE: begin
        low_cnt_d = '0;
        if (!rx_line) begin
          brk_st_d = ulsuf_pkg::BRK_COUNT;
        end
      end
      ulsuf_pkg::BRK_COUNT: begin
        if (rx_line) begin
          brk_st_d = ulsuf_pkg::BRK_IDLE;
        end else if (rx_bit_tick) begin
          if (low_cnt_q + 1'b1 >= rx_frame_bits) begin
            brk_fire = 1'b1;
            brk_st_d = ulsuf_pkg::BRK_HELD;
          end else begin
            low_cnt_d = low_cnt_q + 1'b1;
          end
        end
      end
      ulsuf_pkg::BRK_HELD: begin
        // Stay here until the line returns high so one long break loads once
        if (rx_line) begin
          brk_st_d = ulsuf_pkg::BRK_IDLE;
        end
      end
      default: begin
        brk_st_d = ulsuf_pkg::BRK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      brk_st_q  <= ulsuf_pkg::BRK_IDLE;
      low_cnt_q <= '0;
    end else begin
      brk_st_q  <= brk_st_d;
      low_cnt_q <= low_cnt_d;
    end
  end

  // ****************************************
  // Receive tag store
  // ****************************************
  ulsuf_pkg::ulsuf_tag_t tag_mem [RX_DEPTH];
  logic [AW-1:0]         wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0]         cnt_q, cnt_d, err_q, err_d;
  logic                  push, pop, full, empty;
  ulsuf_pkg::ulsuf_tag_t push_tag, head_tag;

  // A break replaces any character offered in the same cycle
  assign push_tag = brk_fire ? ulsuf_pkg::ulsuf_tag_t'{parity: 1'b0, framing: 1'b1, brk: 1'b1}
                             : rx_char_tag;
  assign empty    = (cnt_q == '0);
  assign full     = (cnt_q == CW'(RX_DEPTH));
  assign head_tag = tag_mem[rp_q];
  // Outside FIFO mode the store acts as a single holding slot that is overwritten
  assign push     = (brk_fire || rx_char_push) && (!full || !fifo_mode);
  assign pop      = rx_char_pop && !empty;

  always_comb begin
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    err_d = err_q;
    if (!fifo_mode) begin
      if (push) begin
        wp_d  = rp_q + 1'b1;
        cnt_d = CW'(1);
        err_d = CW'(tag_any(push_tag));
      end else if (pop) begin
        rp_d  = rp_q + 1'b1;
        cnt_d = '0;
        err_d = '0;
      end
    end else begin
      if (push) begin
        wp_d = wp_q + 1'b1;
      end
      if (pop) begin
        rp_d = rp_q + 1'b1;
      end
      cnt_d = cnt_q + CW'(push) - CW'(pop);
      err_d = err_q + CW'(push && tag_any(push_tag))
                    - CW'(pop && tag_any(head_tag));
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      err_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      err_q <= err_d;
    end
  end

  // Tag memory carries no reset; reads are gated by the occupancy count
  always_ff @(posedge clk_sys) begin
    if (push) begin
      tag_mem[fifo_mode ? wp_q : rp_q] <= push_tag;
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  ulsuf_pkg::ulsuf_status_t st_q, st_d;
  logic                     irq_q, irq_d, bl_q, bl_d;
  ulsuf_pkg::ulsuf_tag_t    next_head;
  logic                     next_empty;

  // Head after this cycle's push and pop, so the flags track the FIFO without lag
  always_comb begin
    next_empty = (cnt_d == '0);
    if (!fifo_mode && push) begin
      next_head = push_tag;
    end else if (fifo_mode && cnt_q == '0 && push) begin
      next_head = push_tag;
    end else if (fifo_mode && pop && cnt_q > CW'(1)) begin
      next_head = tag_mem[rp_q + 1'b1];
    end else if (fifo_mode && pop && push) begin
      next_head = push_tag;
    end else begin
      next_head = head_tag;
    end
  end

  always_comb begin
    st_d = st_q;
    st_d.fifo_error_summary = (err_d != '0);
    st_d.break_flag         = !next_empty && next_head.brk;
    st_d.framing_error_flag = !next_empty && next_head.framing;
    if (fifo_mode) begin
      st_d.tx_holding_empty      = tx_fifo_empty && !tx_host_write;
      st_d.transmitter_all_empty = tx_fifo_empty && tx_shift_empty
                                   && !tx_host_write;
    end else begin
      // A host write in the same cycle as a shift load leaves the register full
      if (tx_host_write) begin
        st_d.tx_holding_empty = 1'b0;
      end else if (tx_load_shift) begin
        st_d.tx_holding_empty = 1'b1;
      end
      st_d.transmitter_all_empty = st_d.tx_holding_empty && tx_shift_empty
                                   && !tx_load_shift;
    end
    irq_d = st_d.tx_holding_empty && thr_int_en;
    bl_d  = brk_fire && fifo_mode;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q  <= '{fifo_error_summary:    ulsuf_pkg::RST_FIFO_ERR,
                 transmitter_all_empty: ulsuf_pkg::RST_TX_EMPTY,
                 tx_holding_empty:      ulsuf_pkg::RST_THR_EMPTY,
                 break_flag:            ulsuf_pkg::RST_BREAK,
                 framing_error_flag:    ulsuf_pkg::RST_FRAMING};
      irq_q <= 1'b0;
      bl_q  <= 1'b0;
    end else begin
      st_q  <= st_d;
      irq_q <= irq_d;
      bl_q  <= bl_d;
    end
  end

  assign line_status = st_q;
  assign thr_irq     = irq_q;
  assign break_load  = bl_q;

endmodule
`default_nettype wire

// ### inc/ulsuf_pkg.sv
// Package: constants and types for the line status upper flags block
package ulsuf_pkg;

  // ****************************************
  // Status bit positions
  // ****************************************
  localparam int unsigned BIT_FIFO_ERR  = 7;
  localparam int unsigned BIT_TX_EMPTY  = 6;
  localparam int unsigned BIT_THR_EMPTY = 5;
  localparam int unsigned BIT_BREAK     = 4;
  localparam int unsigned BIT_FRAMING   = 3;

  // ****************************************
  // Reset values and sizes
  // ****************************************
  localparam logic       RST_FIFO_ERR  = 1'h0;
  localparam logic       RST_TX_EMPTY  = 1'h1;
  localparam logic       RST_THR_EMPTY = 1'h1;
  localparam logic       RST_BREAK     = 1'h0;
  localparam logic       RST_FRAMING   = 1'h0;
  localparam int unsigned RX_DEPTH_DEF = 128;
  localparam int unsigned FRAME_W      = 4;

  // ****************************************
  // Types
  // ****************************************
  // Error tags kept with each received character
  typedef struct packed {
    logic parity;
    logic framing;
    logic brk;
  } ulsuf_tag_t;

  // Upper five bits of the line status register, msb first
  typedef struct packed {
    logic fifo_error_summary;
    logic transmitter_all_empty;
    logic tx_holding_empty;
    logic break_flag;
    logic framing_error_flag;
  } ulsuf_status_t;

  typedef enum logic [1:0] {
    BRK_IDLE,
    BRK_COUNT,
    BRK_HELD
  } ulsuf_brk_state_t;

endpackage

// ### verif/testbench.sv
// Testbench: random traffic against a reference model of the status flags
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 1'h0, nrst = 1'h0, fifo_mode = 1'h0, thr_int_en = 1'h0;
  logic want_write = 1'h0, want_pop = 1'h0, tx_host_write, rx_char_pop;
  logic tx_load_shift = 1'h0, tx_fifo_empty = 1'h1, tx_shift_empty = 1'h1;
  logic rx_line = 1'h1, rx_bit_tick = 1'h0, rx_char_push = 1'h0, thr_irq, break_load;
  logic [3:0] rx_frame_bits = 4'ha;
  ulsuf_pkg::ulsuf_tag_t rx_char_tag = 3'h0;
  ulsuf_pkg::ulsuf_status_t line_status, e_st;
  ulsuf_pkg::ulsuf_tag_t q[$];
  logic e_irq, e_bl, was_low, b5, fire, held;
  int fails = 0, checked = 0, cnt, n, r;
  always #12.5 clk_sys = ~clk_sys;
  ulsuf_host_model i_host (.clk_sys(clk_sys), .want_write(want_write), .want_pop(want_pop),
    .tx_host_write(tx_host_write), .rx_char_pop(rx_char_pop));
  ulsuf_line_status #(.RX_DEPTH(4)) i_ulsuf_line_status (.clk_sys(clk_sys), .nrst(nrst),
    .fifo_mode(fifo_mode), .thr_int_en(thr_int_en), .tx_host_write(tx_host_write),
    .tx_load_shift(tx_load_shift), .tx_fifo_empty(tx_fifo_empty),
    .tx_shift_empty(tx_shift_empty), .rx_line(rx_line), .rx_bit_tick(rx_bit_tick),
    .rx_frame_bits(rx_frame_bits), .rx_char_push(rx_char_push), .rx_char_tag(rx_char_tag),
    .rx_char_pop(rx_char_pop), .line_status(line_status), .thr_irq(thr_irq),
    .break_load(break_load));
  task automatic chk(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  // ****************************************
  // Reference model, compared at every edge
  // ****************************************
  always @(posedge clk_sys) begin
    if (!nrst) begin
      e_st = 5'h0c; e_irq = 1'h0; e_bl = 1'h0; was_low = 1'h0; b5 = 1'h1;
      q.delete(); cnt = 0; held = 1'h0;
    end else begin
      chk(line_status[4], e_st[4], "error summary");
      chk(line_status[3], e_st[3], "all empty");
      chk(line_status[2], e_st[2], "holding empty");
      chk(line_status[1], e_st[1], "break flag");
      chk(line_status[0], e_st[0], "framing flag");
      chk(thr_irq, e_irq, "irq");
      chk(break_load, e_bl, "break load");
      fire = 1'h0;
      // The first low cycle only arms the detector, its tick is not counted
      if (rx_line) begin
        cnt = 0; held = 1'h0;
      end else if (rx_bit_tick && !held && was_low) begin
        cnt++;
        if (cnt == int'(rx_frame_bits)) begin
          fire = 1'h1; held = 1'h1;
        end
      end
      was_low = !rx_line;
      n = q.size();
      // Break entry replaces any character offered in the same cycle
      if (fifo_mode) begin
        if (rx_char_pop && n > 0) void'(q.pop_front());
        if ((rx_char_push || fire) && n < 4) q.push_back(fire ? 3'h3 : rx_char_tag);
      end else begin
        if (rx_char_pop || rx_char_push || fire) q.delete();
        if (rx_char_push || fire) q.push_back(fire ? 3'h3 : rx_char_tag);
      end
      e_st.fifo_error_summary = 1'h0;
      foreach (q[i]) if (q[i] != 3'h0) e_st.fifo_error_summary = 1'h1;
      e_st.break_flag = q.size() > 0 && q[0].brk;
      e_st.framing_error_flag = q.size() > 0 && q[0].framing;
      if (fifo_mode) b5 = tx_fifo_empty && !tx_host_write;
      else if (tx_host_write) b5 = 1'h0;
      else if (tx_load_shift) b5 = 1'h1;
      e_st.tx_holding_empty = b5;
      e_st.transmitter_all_empty = b5 && tx_shift_empty && (fifo_mode || !tx_load_shift);
      e_irq = b5 && thr_int_en;
      e_bl = fire && fifo_mode;
    end
  end
  task automatic finish_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ****************************************
  // Stimulus: one random phase per mode
  // ****************************************
  initial begin
    void'($urandom(32'hba25));
    for (int m = 0; m < 2; m++) begin
      nrst <= 1'h0;
      fifo_mode <= m[0];
      rx_frame_bits <= 4'(7 + $urandom % 5);
      repeat (3) @(posedge clk_sys);
      nrst <= 1'h1;
      for (int c = 0; c < 3000; c++) begin
        @(posedge clk_sys);
        r = $urandom % 6;
        want_pop <= (r == 0);
        rx_char_push <= (r >= 3) && !want_pop;
        rx_char_tag <= 3'($urandom);
        want_write <= ($urandom % 4 == 0);
        tx_load_shift <= ($urandom % 4 == 0);
        tx_fifo_empty <= $urandom % 2;
        tx_shift_empty <= $urandom % 2;
        thr_int_en <= $urandom % 2;
        rx_bit_tick <= ($urandom % 3 == 0);
        if ($urandom % 40 == 0) rx_line <= ~rx_line;
      end
      $display("test mode %0d done", m);
    end
    finish_test();
  end
endmodule
`default_nettype wire

// ### verif/ulsuf_chk.sv
// Checker: assertions on the line status flags
`timescale 1ns/1ps
`default_nettype none
module ulsuf_chk #(
  parameter int unsigned RX_DEPTH = 4
) (
  // Clock, reset, controls
  input wire logic                     clk_sys,
  input wire logic                     nrst,
  input wire logic                     fifo_mode,
  input wire logic                     thr_int_en,
  // Inputs
  input wire logic                     tx_host_write,
  input wire logic                     tx_load_shift,
  input wire logic                     tx_fifo_empty,
  input wire logic                     tx_shift_empty,
  input wire logic                     rx_line,
  input wire logic                     rx_char_push,
  input wire ulsuf_pkg::ulsuf_tag_t    rx_char_tag,
  input wire logic                     rx_char_pop,
  // Outputs
  input wire ulsuf_pkg::ulsuf_status_t line_status,
  input wire logic                     thr_irq,
  input wire logic                     break_load
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  reset_vals_a: assert property ($rose(nrst) |-> line_status == 5'h0c)
    else $error("status wrong after reset");
  irq_level_a: assert property ($past(nrst) |-> thr_irq ==
    (line_status.tx_holding_empty && $past(thr_int_en))) else $error("irq mismatch");
  write_clear_a: assert property (tx_host_write |=> !line_status.tx_holding_empty)
    else $error("write left b5 set");
  fifo_thre_a: assert property (fifo_mode && tx_fifo_empty && !tx_host_write
    |=> line_status.tx_holding_empty) else $error("fifo b5 not set");
  fifo_temt_a: assert property (fifo_mode && tx_fifo_empty && tx_shift_empty
    && !tx_host_write |=> line_status.transmitter_all_empty) else $error("fifo b6 not set");
  busy_temt_a: assert property (!fifo_mode && !tx_shift_empty
    |=> !line_status.transmitter_all_empty) else $error("b6 set while busy");
  load_thre_a: assert property (!fifo_mode && tx_load_shift && !tx_host_write
    |=> line_status.tx_holding_empty) else $error("load left b5 clear");
  break_once_a: assert property (break_load |-> !$past(rx_line)
    && $past(fifo_mode) ##1 !break_load) else $error("bad break load");
  slot_tags_a: assert property (!fifo_mode && rx_char_push && !rx_char_pop && rx_line
    |=> line_status.framing_error_flag == $past(rx_char_tag.framing)
    && line_status.fifo_error_summary == (|$past(rx_char_tag))) else $error("slot flags wrong");
  cover property (break_load);
  cover property ($rose(line_status.fifo_error_summary));
  cover property (thr_irq);
endmodule
bind ulsuf_line_status ulsuf_chk #(.RX_DEPTH(RX_DEPTH)) i_chk (.clk_sys(clk_sys), .nrst(nrst),
  .fifo_mode(fifo_mode), .thr_int_en(thr_int_en), .tx_host_write(tx_host_write),
  .tx_load_shift(tx_load_shift), .tx_fifo_empty(tx_fifo_empty), .tx_shift_empty(tx_shift_empty),
  .rx_line(rx_line), .rx_char_push(rx_char_push), .rx_char_tag(rx_char_tag),
  .rx_char_pop(rx_char_pop), .line_status(line_status), .thr_irq(thr_irq),
  .break_load(break_load));
`default_nettype wire

// ### verif/ulsuf_host_model.sv
// Host model: registered holding writes and receive pops
`timescale 1ns/1ps
`default_nettype none
module ulsuf_host_model (
  // Clock and requests from the bench
  input  wire logic clk_sys,
  input  wire logic want_write,
  input  wire logic want_pop,
  // Host strobes
  output logic      tx_host_write,
  output logic      rx_char_pop
);
  // Strobes launch one cycle after the request, like a host bus cycle
  always_ff @(posedge clk_sys) begin
    tx_host_write <= want_write;
    rx_char_pop   <= want_pop;
  end
endmodule
`default_nettype wire
